// ---- arc_core.sv ----
// Ready pulse generation, restart control, double-buffered sample,
// read-sequence CRC and register write lock for one converter channel.
// Assumes the serial framer runs on ref_clk_i and hands over bit,
// read and write events as one-cycle pulses on that clock.
`timescale 1ns/100ps

// Summary of operation
// - Phase write or timing setting change restarts an active converter.
// - Restart clears the first sample stage; conversion resumes with no command.
// - Each conversion gives a low ready pulse of half a master clock.
// - First pulse after settle plus phase, then one per data-rate period.
// - Idle ready pin floats when drive bit clear, drives high when set.
// - Ready pulses ignore chip select; pin inactive while reset held.
// - Configuration mismatch flag holds the ready pin low.
// - First sample stage captures each result on the ready event.
// - Second stage freezes at read start until the read completes.
// - Status ready bit reads 0 while fresh data wait.
// - With checksum enabled, CRC follows the last address of the set.
// - Checksum polynomial is x16+x15+x2+1, 0x8005.
// - Always a 16-bit CRC, shown in 16- or 32-bit field by width bit.
// - Key at 0x1F; value 0xA5, the default, accepts writes to 0x08 and above.
// - Key not 0xA5 makes every address but 0x1F read-only.
// - Writes to read-only addresses ignored; undefined ones from 0x08 up accepted.
// - Mismatch holds ready low until unlock clears the flag.
module arc_core #(
  parameter logic [19:0] SETTLE_CYC = 20'h0_1000
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic soft_reset_i,
  input wire logic shutdown_i,
  input wire logic [2:0] osr_i,
  input wire logic [1:0] prescale_i,
  input wire logic external_clock_sel_i,
  input wire logic external_reference_sel_i,
  input wire logic [11:0] phase_delay_i,
  input wire logic [15:0] rate_period_i,
  input wire logic [23:0] adc_result_i,
  input wire logic ready_idle_drive_i,
  input wire logic cfg_mismatch_i,
  input wire logic [15:0] config_checksum_value_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic [4:0] rd_addr_i,
  input wire logic read_start_i,
  input wire logic read_done_i,
  input wire logic comm_checksum_enable_i,
  input wire logic width_hi_i,
  input wire logic tx_bit_valid_i,
  input wire logic tx_bit_i,
  input wire logic seq_end_i,
  input wire logic frame_idle_i,
  output logic sample_ready_n_o,
  output logic sample_ready_n_oe_o,
  output logic ready_flag_bit_o,
  output logic [23:0] sample_read_o,
  output logic [23:0] rd_data_o,
  output logic reg_wr_ok_o,
  output logic [7:0] lock_key_o,
  output logic mismatch_o,
  output logic crc_valid_o,
  output logic [31:0] crc_field_o
);
  // ---------------------------------------------------------------
  // Write acceptance and lock key
  // ---------------------------------------------------------------
  logic [7:0] lock_key;
  logic unlocked;
  logic wr_take;
  assign unlocked = (lock_key == arc_pkg::KEY_PASSWORD);
  assign wr_take = reg_wr_i && (reg_addr_i >= arc_pkg::ADDR_FIRST_WR)
                   && (unlocked || reg_addr_i == arc_pkg::ADDR_KEY);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_key <= arc_pkg::KEY_RESET;
      reg_wr_ok_o <= 1'b0;
    end else begin
      reg_wr_ok_o <= wr_take;
      if (wr_take && reg_addr_i == arc_pkg::ADDR_KEY) begin
        lock_key <= reg_wdata_i[arc_pkg::KEY_MSB:arc_pkg::KEY_LSB];
      end
    end
  end
  assign lock_key_o = lock_key;

  // ---------------------------------------------------------------
  // Restart detection
  // ---------------------------------------------------------------
  logic [2:0] osr_q;
  logic [1:0] pre_q;
  logic ext_clk_q;
  logic vref_q;
  logic active;
  logic restart;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osr_q <= 3'h0;
      pre_q <= 2'h0;
      ext_clk_q <= 1'b0;
      vref_q <= 1'b0;
    end else begin
      osr_q <= osr_i;
      pre_q <= prescale_i;
      ext_clk_q <= external_clock_sel_i;
      vref_q <= external_reference_sel_i;
    end
  end
  assign active = !soft_reset_i && !shutdown_i;
  // A same-value phase write also restarts, which gives software a serial soft reset
  assign restart = active && ((wr_take && reg_addr_i == arc_pkg::ADDR_PHASE)
                   || osr_i != osr_q || prescale_i != pre_q
                   || external_clock_sel_i != ext_clk_q
                   || external_reference_sel_i != vref_q);

  // ---------------------------------------------------------------
  // Conversion timing
  // ---------------------------------------------------------------
  arc_pkg::arc_conv_t state;
  logic [19:0] cnt;
  logic conv_evt;
  // The pulse is a local event only; chip select never reaches this counter
  assign conv_evt = (state != arc_pkg::ARC_IDLE) && !restart
                    && cnt == arc_pkg::CNT_ONE;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= arc_pkg::ARC_IDLE;
      cnt <= arc_pkg::CNT_ZERO;
    end else if (!active) begin
      state <= arc_pkg::ARC_IDLE;
      cnt <= arc_pkg::CNT_ZERO;
    end else if (restart || state == arc_pkg::ARC_IDLE) begin
      state <= arc_pkg::ARC_SETTLE;
      cnt <= 20'(SETTLE_CYC + {8'h00, phase_delay_i});
    end else if (conv_evt) begin
      state <= arc_pkg::ARC_RUN;
      cnt <= {4'h0, rate_period_i};
    end else begin
      cnt <= 20'(cnt - arc_pkg::CNT_ONE);
    end
  end

  // ---------------------------------------------------------------
  // Sample stages and ready flag
  // ---------------------------------------------------------------
  logic [23:0] stage1;
  logic read_busy;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= arc_pkg::SAMPLE_RESET;
    end else if (restart) begin
      stage1 <= arc_pkg::SAMPLE_RESET;
    end else if (conv_evt) begin
      stage1 <= adc_result_i;
    end
  end

  // A read in progress keeps its word; the next sample waits for read_done_i
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sample_read_o <= arc_pkg::SAMPLE_RESET;
      read_busy <= 1'b0;
    end else if (read_start_i && !read_busy) begin
      sample_read_o <= stage1;
      read_busy <= 1'b1;
    end else if (read_done_i) begin
      read_busy <= 1'b0;
    end
  end

  // New data wins over the clear by a read start in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_flag_bit_o <= 1'b1;
    end else if (conv_evt) begin
      ready_flag_bit_o <= 1'b0;
    end else if (restart || (read_start_i && !read_busy)) begin
      ready_flag_bit_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Ready pin
  // ---------------------------------------------------------------
  logic [3:0] low_cnt;
  logic next_mismatch;
  logic next_low;
  assign next_mismatch = (mismatch_o && !unlocked) || cfg_mismatch_i;
  assign next_low = conv_evt || low_cnt > 4'h1;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt <= 4'h0;
    end else if (conv_evt) begin
      low_cnt <= arc_pkg::READY_LOW_CYC;
    end else if (low_cnt != 4'h0) begin
      low_cnt <= low_cnt - 4'h1;
    end
  end

  // Pin floats during reset so shared ready lines stay quiet
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mismatch_o <= 1'b0;
      sample_ready_n_o <= 1'b1;
      sample_ready_n_oe_o <= 1'b0;
    end else begin
      mismatch_o <= next_mismatch;
      if (next_low || next_mismatch) begin
        sample_ready_n_o <= 1'b0;
        sample_ready_n_oe_o <= 1'b1;
      end else begin
        sample_ready_n_o <= 1'b1;
        sample_ready_n_oe_o <= ready_idle_drive_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 24'h00_0000;
    end else if (rd_addr_i == arc_pkg::ADDR_SAMPLE) begin
      rd_data_o <= sample_read_o;
    end else if (rd_addr_i == arc_pkg::ADDR_KEY) begin
      rd_data_o <= {lock_key, config_checksum_value_i};
    end else begin
      rd_data_o <= 24'h00_0000;
    end
  end

  // ---------------------------------------------------------------
  // Communication checksum
  // ---------------------------------------------------------------
  logic [15:0] crc;
  logic [15:0] next_crc;
  always_comb begin
    next_crc = crc;
    if (tx_bit_valid_i) begin
      next_crc = {crc[14:0], 1'b0}
                 ^ ((crc[15] ^ tx_bit_i) ? arc_pkg::CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crc <= arc_pkg::CRC_INIT;
      crc_valid_o <= 1'b0;
      crc_field_o <= 32'h0000_0000;
    end else begin
      crc_valid_o <= seq_end_i && comm_checksum_enable_i;
      if (seq_end_i && comm_checksum_enable_i) begin
        // Same 16-bit value either way; width bit only sets the field
        crc_field_o <= width_hi_i ? {next_crc, arc_pkg::CRC_PAD}
                                  : {16'h0000, next_crc};
      end
      if (frame_idle_i || seq_end_i) begin
        crc <= arc_pkg::CRC_INIT;
      end else begin
        crc <= next_crc;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  localparam int UPD_BOUND = arc_pkg::UPD_CYC;
  ready_width_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $fell(sample_ready_n_o) && !mismatch_o |=> sample_ready_n_o || mismatch_o)
    else $error("ready pulse longer than one cycle");
  idle_drive_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 sample_ready_n_o |-> sample_ready_n_oe_o == $past(ready_idle_drive_i))
    else $error("idle ready drive wrong");
  mismatch_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mismatch_o |-> !sample_ready_n_o && sample_ready_n_oe_o)
    else $error("ready not held low on mismatch");
  stage_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    conv_evt |-> ##[1:UPD_BOUND] stage1 == $past(adc_result_i, 1))
    else $error("sample not captured in time");
  restart_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    restart |=> stage1 == arc_pkg::SAMPLE_RESET && state == arc_pkg::ARC_SETTLE)
    else $error("restart did not clear sample");
  restart_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    restart |=> !conv_evt [*2])
    else $error("pulse right after restart");
  freeze_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    read_busy && !read_done_i |=> $stable(sample_read_o))
    else $error("sample changed during read");
  ready_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    conv_evt |=> !ready_flag_bit_o ##1 (!ready_flag_bit_o || $past(read_start_i)
    || $past(restart)))
    else $error("ready flag not showing fresh data");
  lock_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    reg_wr_i && !unlocked && reg_addr_i != arc_pkg::ADDR_KEY |=> !reg_wr_ok_o)
    else $error("locked write accepted");
  crc_field_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    crc_valid_o && !$past(width_hi_i) |-> crc_field_o[31:16] == 16'h0000)
    else $error("short checksum field not zero padded");
  first_pulse_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    state == arc_pkg::ARC_SETTLE && conv_evt);
  read_freeze_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    read_busy && conv_evt);
  crc_out_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    crc_valid_o && width_hi_i);
  relock_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mismatch_o ##1 !mismatch_o);
endmodule

// ---- arc_pkg.sv ----
// Constants for the converter ready, checksum and lock support logic.
// Assumes a single 200 MHz reference clock drives every flip-flop.
package arc_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  // Digital master clock as a count of reference cycles
  localparam int MASTER_DIV = 2;
  localparam logic [3:0] READY_LOW_CYC = 4'(MASTER_DIV / 2);
  // Output update delay, a longest time, so rounded down
  localparam int UPD_NS = 10;
  localparam int UPD_CYC_RAW = (UPD_NS * 1000) / CLK_PERIOD_PS;
  localparam int UPD_CYC = (UPD_CYC_RAW < 1) ? 1 : UPD_CYC_RAW;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_SAMPLE = 5'h00;
  localparam logic [4:0] ADDR_FIRST_WR = 5'h08;
  localparam logic [4:0] ADDR_PHASE = 5'h0a;
  localparam logic [4:0] ADDR_KEY = 5'h1f;
  localparam int KEY_MSB = 23;
  localparam int KEY_LSB = 16;
  localparam logic [7:0] KEY_PASSWORD = 8'ha5;
  localparam logic [7:0] KEY_RESET = 8'ha5;
  localparam logic [23:0] SAMPLE_RESET = 24'h00_0000;
  // ---------------------------------------------------------------
  // Communication checksum, counter steps and conversion states
  // ---------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_PAD = 16'h0000;
  localparam logic [19:0] CNT_ONE = 20'h0_0001;
  localparam logic [19:0] CNT_ZERO = 20'h0_0000;
  typedef enum logic [1:0] {ARC_IDLE, ARC_SETTLE, ARC_RUN} arc_conv_t;
endpackage

// ---- arc_host.sv ----
// Host-side model: the shared ready wire and the host's read timing.
// Assumes the host shares ref_clk_i and the wire carries a pull-up.
`timescale 1ns/100ps
module arc_host (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic level_o,
  output logic read_go_o,
  output logic [15:0] gap_o
);
  logic last;
  logic [3:0] wait_cnt;
  logic [15:0] cnt;
  // Pull-up lets several devices share the wire while it floats
  assign level_o = pin_oe_i ? pin_i : 1'b1;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last <= 1'b1;
      wait_cnt <= 4'h0;
      cnt <= 16'h0000;
      gap_o <= 16'h0000;
      read_go_o <= 1'b0;
    end else begin
      last <= level_o;
      cnt <= cnt + 16'h0001;
      read_go_o <= (wait_cnt == 4'h1);
      if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      if (last && !level_o) begin
        gap_o <= cnt;
        cnt <= 16'h0001;
        // Reading earlier than the update delay may catch stale data
        wait_cnt <= 4'(arc_pkg::UPD_CYC);
      end
    end
  end
endmodule

// ---- test_adc_ready_crc_lock_logic.sv ----
// Self-checking bench for the converter ready, checksum and lock logic.
// Assumes arc_core and arc_host are compiled first; drives on falling edges.
`timescale 1ns/100ps
module test_adc_ready_crc_lock_logic;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic soft_rst = 1'b0, shut = 1'b0, ext_clk = 1'b0, ext_ref = 1'b0, idle_drv = 1'b0;
  logic mism = 1'b0, wr = 1'b0, rs = 1'b0, rd_done = 1'b0, crc_en = 1'b0, wide = 1'b0;
  logic tv = 1'b0, tb = 1'b0, se = 1'b0, fidle = 1'b0;
  logic [2:0] osr = 3'h3;
  logic [1:0] pre = 2'h0;
  logic [11:0] phase = 12'h040;
  logic [15:0] period = 16'h0014;
  logic [15:0] cfgsum = 16'hbeef;
  logic [23:0] adc = 24'h12_3456;
  logic [23:0] wdata = 24'h00_0000;
  logic [4:0] addr = 5'h00, raddr = 5'h00;
  logic pin, pin_oe, flag, wr_ok, mism_o, crc_v, level, go;
  logic [23:0] samp, rdat;
  logic [7:0] key;
  logic [31:0] crcf;
  logic [15:0] gap;
  int bad_count = 0;
  int checked = 0;
  int n;
  always #2.5 clk = ~clk;
  arc_core #(.SETTLE_CYC(20'h0_0010)) DUT (.ref_clk_i(clk), .rst_b_i(rst_b),
    .soft_reset_i(soft_rst), .shutdown_i(shut), .osr_i(osr), .prescale_i(pre),
    .external_clock_sel_i(ext_clk), .external_reference_sel_i(ext_ref),
    .phase_delay_i(phase), .rate_period_i(period), .adc_result_i(adc),
    .ready_idle_drive_i(idle_drv), .cfg_mismatch_i(mism), .config_checksum_value_i(cfgsum),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .rd_addr_i(raddr),
    .read_start_i(rs), .read_done_i(rd_done), .comm_checksum_enable_i(crc_en),
    .width_hi_i(wide), .tx_bit_valid_i(tv), .tx_bit_i(tb), .seq_end_i(se),
    .frame_idle_i(fidle), .sample_ready_n_o(pin), .sample_ready_n_oe_o(pin_oe),
    .ready_flag_bit_o(flag), .sample_read_o(samp), .rd_data_o(rdat), .reg_wr_ok_o(wr_ok),
    .lock_key_o(key), .mismatch_o(mism_o), .crc_valid_o(crc_v), .crc_field_o(crcf));
  arc_host HOST (.clk_i(clk), .rst_b_i(rst_b), .pin_i(pin), .pin_oe_i(pin_oe),
    .level_o(level), .read_go_o(go), .gap_o(gap));
  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [23:0] d, input logic ok);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    chk(32'(wr_ok), 32'(ok));
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [23:0] exp);
    @(negedge clk);
    raddr = a;
    @(negedge clk);
    chk(32'(rdat), 32'(exp));
  endtask
  task automatic pulse_rs(input logic done);
    @(negedge clk);
    rd_done = done;
    rs = ~done;
    @(negedge clk);
    rd_done = 1'b0;
    rs = 1'b0;
  endtask
  // Bounded wait for the host's read trigger; n counts cycles waited
  task automatic wait_go(output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
      if (cyc > 3000) begin
        bad_count++;
        $display("mismatch at %0t: no ready pulse", $time);
        close_out();
      end
    end while (go !== 1'b1);
  endtask
  // Own reference CRC, written independently of the design
  function automatic logic [15:0] crc_of(input logic [47:0] m, input int len);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = len - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ (((c[15] ^ m[i]) == 1'b1) ? 16'h8005 : 16'h0000);
    end
    return c;
  endfunction
  task automatic send_seq(input logic [31:0] w, input logic hi, input logic en);
    logic [15:0] c;
    c = crc_of({16'h0000, w}, 32);
    crc_en = en;
    wide = hi;
    // Junk bits then an idle frame: the checksum must forget them
    repeat (5) begin
      @(negedge clk);
      tv = 1'b1;
      tb = 1'b1;
    end
    @(negedge clk);
    tv = 1'b0;
    fidle = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(negedge clk);
      fidle = 1'b0;
      tv = 1'b1;
      tb = w[i];
    end
    @(negedge clk);
    tv = 1'b0;
    se = 1'b1;
    @(negedge clk);
    se = 1'b0;
    chk(32'(crc_v), 32'(en));
    if (en) chk(crcf, hi ? {c, 16'h0000} : {16'h0000, c});
    chk(32'(crc_of({w, c}, 48)), 32'h0000_0000);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    chk(32'(pin_oe), 32'h0000_0000);
    rst_b = 1'b1;
    chk(32'(key), 32'h0000_00a5);
    chk(32'(pin_oe), 32'h0000_0000);
    wait_go(n);
    chk(32'(flag), 32'h0000_0000);
    pulse_rs(1'b0);
    chk(32'(samp), 32'(adc));
    chk(32'(flag), 32'h0000_0001);
    adc = 24'hab_cdef;
    wait_go(n);
    chk(32'(gap), 32'(period));
    pulse_rs(1'b0);
    chk(32'(samp), 32'h0012_3456);
    pulse_rs(1'b1);
    pulse_rs(1'b0);
    chk(32'(samp), 32'(adc));
    rd_reg(5'h00, adc);
    wait_go(n);
    chk(32'(level), 32'h0000_0001);
    idle_drv = 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({pin_oe, pin}), 32'h0000_0003);
    // Each restart cause in turn, timed from the read after the change to the next pulse
    for (int i = 0; i < 5; i++) begin
      wait_go(n);
      case (i)
        0: osr = osr + 3'h1;
        1: pre = pre + 2'h1;
        2: ext_clk = ~ext_clk;
        3: ext_ref = ~ext_ref;
        default: wr_reg(5'h0a, 24'h00_0040, 1'b1);
      endcase
      pulse_rs(1'b1);
      pulse_rs(1'b0);
      chk(32'(samp), 32'h0000_0000);
      wait_go(n);
      chk(32'(n inside {[70:100]}), 32'h0000_0001);
    end
    // Soft reset, then shutdown: silent while held, settles again after
    for (int k = 0; k < 2; k++) begin
      soft_rst = (k == 0);
      shut = (k == 1);
      n = 0;
      repeat (150) begin
        @(negedge clk);
        if (go === 1'b1) n++;
      end
      chk(32'(n), 32'h0000_0000);
      soft_rst = 1'b0;
      shut = 1'b0;
      wait_go(n);
    end
    wr_reg(5'h09, 24'h00_0001, 1'b1);
    wr_reg(5'h05, 24'h00_0001, 1'b0);
    wr_reg(5'h1f, 24'h00_0000, 1'b1);
    chk(32'(key), 32'h0000_0000);
    wr_reg(5'h09, 24'h00_0002, 1'b0);
    wr_reg(5'h0a, 24'h00_0040, 1'b0);
    rd_reg(5'h1f, {8'h00, cfgsum});
    @(negedge clk);
    mism = 1'b1;
    @(negedge clk);
    mism = 1'b0;
    n = 0;
    repeat (60) begin
      @(negedge clk);
      if (level !== 1'b0) n++;
    end
    chk(32'(n), 32'h0000_0000);
    wr_reg(5'h1f, 24'ha5_0000, 1'b1);
    repeat (2) @(negedge clk);
    chk(32'(mism_o), 32'h0000_0000);
    send_seq(32'h8000_0001, 1'b0, 1'b1);
    send_seq(32'h1234_5678, 1'b1, 1'b1);
    send_seq(32'hffff_0000, 1'b0, 1'b0);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk(32'({pin_oe, flag, key}), 32'h0000_01a5);
    close_out();
  end
endmodule
